// ===== design/pmr_pkg.sv
package pmr_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_PWR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PWR_MODE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_WD_CTRL = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int IDLE_REQ_POS = 0;
    localparam int DIV_LO_POS = 6;
    localparam int DIV_HI_POS = 7;
    localparam int WD_RESTART_POS = 0;
    localparam int WD_RST_EN_POS = 1;
    localparam int WD_RST_FLAG_POS = 2;
    localparam int WD_TO_FLAG_POS = 3;
    localparam int WD_RUN_POS = 4;
    localparam int ST_IDLE_POS = 0;
    localparam int ST_RST_POS = 1;
    localparam int ST_PFAIL_POS = 2;

    // ----------------------------------------
    // clock divide codes and reset values
    // ----------------------------------------
    localparam logic [1:0] DIV_RSVD = 2'h0;
    localparam logic [1:0] DIV_4 = 2'h1;
    localparam logic [1:0] DIV_64 = 2'h2;
    localparam logic [1:0] DIV_1024 = 2'h3;
    localparam logic [1:0] DIV_RESET = DIV_4;
    localparam logic [15:0] PC_RESET_VAL = 16'h0000;
    localparam logic [7:0] SP_RESET_VAL = 8'h07;
    localparam logic [7:0] PORT_RESET_VAL = 8'hff;

    // ----------------------------------------
    // timing counts (clocks, machine cycles or peripheral ticks)
    // ----------------------------------------
    localparam logic [9:0] MC_MAX_4 = 10'h003;
    localparam logic [9:0] MC_MAX_64 = 10'h03f;
    localparam logic [9:0] MC_MAX_1024 = 10'h3ff;
    localparam logic [1:0] IDLE_TICK_MAX = 2'h3;
    localparam logic [1:0] RST_EXT_MC = 2'h2;
    localparam logic [9:0] WD_RST_DELAY = 10'h200;
    localparam int WD_TIMEOUT_DEF = 131072;
endpackage

// ===== design/wdog_timer.sv
`timescale 1ns/1ps
module wdog_timer
    import pmr_pkg::*;
#(
    parameter int TIMEOUT_TICKS = WD_TIMEOUT_DEF
)(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic clear_i,
    input wire logic rst_en_i,
    output logic timeout_o,
    output logic wd_rst_o
);
    import pmr_pkg::*;

    localparam int CW = $clog2(TIMEOUT_TICKS + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(TIMEOUT_TICKS - 1);

    generate
        if (TIMEOUT_TICKS < 2)
        begin : g_chk
            $error("wdog_timer: TIMEOUT_TICKS must be at least 2");
        end
    endgenerate

    logic [CW-1:0] cnt_q;
    logic armed_q;
    logic [9:0] dly_q;
    logic hit;

    assign hit = run_i && !clear_i && tick_i && (cnt_q == CNT_MAX);

    // ----------------------------------------
    // interval counter
    // ----------------------------------------
    // clear restarts count
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_q <= '0;
        else if (!run_i || clear_i || hit)
            cnt_q <= '0;
        else if (tick_i)
            cnt_q <= cnt_q + 1'b1;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            timeout_o <= 1'b0;
        else
            timeout_o <= hit;
    end

    // ----------------------------------------
    // reset delay after timeout, in clocks
    // ----------------------------------------
    // reset 512 clocks later
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            armed_q <= 1'b0;
            dly_q <= '0;
            wd_rst_o <= 1'b0;
        end
        else
        begin
            wd_rst_o <= 1'b0;
            if (clear_i || !run_i)
            begin
                armed_q <= 1'b0;
                dly_q <= '0;
            end
            // a later timeout must not restart a pending reset delay
            else if (hit && !armed_q)
            begin
                armed_q <= 1'b1;
                dly_q <= 10'h001;
            end
            else if (armed_q)
            begin
                dly_q <= dly_q + 1'b1;
                if (dly_q == WD_RST_DELAY - 10'h001)
                begin
                    armed_q <= 1'b0;
                    wd_rst_o <= rst_en_i;
                end
            end
        end
    end
endmodule

// ===== design/power_reset_ctrl.sv
`timescale 1ns/1ps
module power_reset_ctrl
    import pmr_pkg::*;
#(
    parameter int WD_TIMEOUT_TICKS = WD_TIMEOUT_DEF
)(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [pmr_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic rst_pin_i,
    input wire logic pwr_fail_pin_i,
    input wire logic irq_wake_i,
    output logic cpu_clk_en_o,
    output logic strobe_high_o,
    output logic port_hold_o,
    output logic core_rst_o,
    output logic [15:0] pc_reset_o,
    output logic [7:0] sp_reset_o,
    output logic [7:0] port_reset_o,
    output logic mc_tick_o,
    output logic fourth_phase_state_o,
    output logic periph_tick_o,
    output logic wd_flag_o
);
    import pmr_pkg::*;

    typedef enum logic [1:0] {
        RS_RUN = 2'b00,
        RS_HOLD = 2'b01,
        RS_EXT = 2'b10
    } rst_state_t;

    function automatic logic [9:0] mc_max(input logic [1:0] sel);
        case (sel)
            DIV_64: mc_max = MC_MAX_64;
            DIV_1024: mc_max = MC_MAX_1024;
            default: mc_max = MC_MAX_4;
        endcase
    endfunction

    logic [2:0] pin_s_q;
    logic [2:0] pf_s_q;
    logic pin_lvl_q;
    logic por_lvl_q;
    logic samp_q;
    logic pin_det;
    rst_state_t st_q;
    rst_state_t st_d;
    logic [1:0] ext_q;
    logic rst_req;
    logic idle_q;
    logic idle_d;
    logic [1:0] div_sel_q;
    logic [9:0] div_cnt_q;
    logic mc_end;
    logic [1:0] q4_q;
    logic wait_q;
    logic wr_acc;
    logic be0;
    logic restart_q;
    logic wd_rst_en_q;
    logic wd_run_q;
    logic watchdog_timeout_flag_q;
    logic watchdog_reset_flag_q;
    logic pfail_q;
    logic wd_to;
    logic wd_rst;

    assign be0 = avs_byteenable_i[0];
    assign wr_acc = avs_write_i && !wait_q && be0;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_s_q <= '0;
            pf_s_q <= '0;
            pin_lvl_q <= 1'b0;
            por_lvl_q <= 1'b0;
        end
        else
        begin
            pin_s_q <= {pin_s_q[1:0], rst_pin_i};
            pf_s_q <= {pf_s_q[1:0], pwr_fail_pin_i};
            if (pin_s_q[1] == pin_s_q[2])
                pin_lvl_q <= pin_s_q[2];
            if (pf_s_q[1] == pf_s_q[2])
                por_lvl_q <= pf_s_q[2];
        end
    end

    // ----------------------------------------
    // machine cycle divider
    // ----------------------------------------
    // clocks per machine cycle
    assign mc_end = div_cnt_q >= mc_max(div_sel_q);

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            div_cnt_q <= '0;
        else if (mc_end)
            div_cnt_q <= '0;
        else
            div_cnt_q <= div_cnt_q + 1'b1;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            div_sel_q <= DIV_RESET;
        else if (rst_req)
            div_sel_q <= DIV_RESET;
        else if (wr_acc && avs_address_i == OFS_PWR_MODE
                 && avs_writedata_i[DIV_HI_POS:DIV_LO_POS] != DIV_RSVD)
            div_sel_q <= avs_writedata_i[DIV_HI_POS:DIV_LO_POS];
    end

    // ----------------------------------------
    // peripheral tick
    // ----------------------------------------
    // quarter-rate count runs free so idle entry needs no resync
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            q4_q <= '0;
            periph_tick_o <= 1'b0;
            mc_tick_o <= 1'b0;
            fourth_phase_state_o <= 1'b0;
        end
        else
        begin
            q4_q <= q4_q + 1'b1;
            periph_tick_o <= idle_q ? (q4_q == IDLE_TICK_MAX) : mc_end;
            mc_tick_o <= mc_end;
            fourth_phase_state_o <= mc_end;
        end
    end

    // ----------------------------------------
    // reset sequencing
    // ----------------------------------------
    // two samples, one per cycle
    assign pin_det = mc_end && pin_lvl_q && samp_q;

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            samp_q <= 1'b0;
        else if (mc_end)
            samp_q <= pin_lvl_q;
    end

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            RS_RUN:
            begin
                if (por_lvl_q || pin_det)
                    st_d = RS_HOLD;
                else if (wd_rst)
                    st_d = RS_EXT;
            end
            RS_HOLD:
            begin
                if (!por_lvl_q && !pin_lvl_q)
                    st_d = RS_EXT;
            end
            RS_EXT:
            begin
                if (por_lvl_q || pin_det)
                    st_d = RS_HOLD;
                else if (mc_end && ext_q == RST_EXT_MC - 2'h1)
                    st_d = RS_RUN;
            end
            default: st_d = RS_HOLD;
        endcase
    end

    assign rst_req = st_d != RS_RUN;

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q <= RS_HOLD;
            ext_q <= '0;
            core_rst_o <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            // two more machine cycles
            // only ends seen inside RS_EXT count, so the tail is never short
            if (st_d != RS_EXT)
                ext_q <= '0;
            else if (mc_end && st_q == RS_EXT)
                ext_q <= ext_q + 1'b1;
            core_rst_o <= rst_req;
        end
    end

    // ram has no reset path here
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pc_reset_o <= PC_RESET_VAL;
            sp_reset_o <= SP_RESET_VAL;
            port_reset_o <= PORT_RESET_VAL;
        end
        else
        begin
            pc_reset_o <= PC_RESET_VAL;
            sp_reset_o <= SP_RESET_VAL;
            port_reset_o <= PORT_RESET_VAL;
        end
    end

    // ----------------------------------------
    // idle control
    // ----------------------------------------
    always_comb
    begin
        idle_d = idle_q;
        if (rst_req)
            idle_d = 1'b0;
        else if (idle_q && irq_wake_i)
            idle_d = 1'b0;
        else if (wr_acc && avs_address_i == OFS_PWR_CTRL
                 && avs_writedata_i[IDLE_REQ_POS])
            idle_d = 1'b1;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            idle_q <= 1'b0;
            cpu_clk_en_o <= 1'b1;
            strobe_high_o <= 1'b0;
            port_hold_o <= 1'b0;
        end
        else
        begin
            idle_q <= idle_d;
            cpu_clk_en_o <= !idle_d;
            strobe_high_o <= idle_d;
            port_hold_o <= idle_d;
        end
    end

    // ----------------------------------------
    // watchdog control and flags
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            restart_q <= 1'b0;
            wd_rst_en_q <= 1'b0;
            wd_run_q <= 1'b0;
        end
        else
        begin
            restart_q <= wr_acc && avs_address_i == OFS_WD_CTRL
                         && avs_writedata_i[WD_RESTART_POS];
            if (por_lvl_q)
            begin
                wd_rst_en_q <= 1'b0;
                wd_run_q <= 1'b0;
            end
            else if (wr_acc && avs_address_i == OFS_WD_CTRL)
            begin
                wd_rst_en_q <= avs_writedata_i[WD_RST_EN_POS];
                wd_run_q <= avs_writedata_i[WD_RUN_POS];
            end
        end
    end

    // hardware set wins over a clearing write
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            watchdog_timeout_flag_q <= 1'b0;
            watchdog_reset_flag_q <= 1'b0;
            pfail_q <= 1'b0;
            wd_flag_o <= 1'b0;
        end
        else
        begin
            if (wd_to)
                watchdog_timeout_flag_q <= 1'b1;
            else if (rst_req
                     || (wr_acc && avs_address_i == OFS_WD_CTRL
                         && !avs_writedata_i[WD_TO_FLAG_POS]))
                watchdog_timeout_flag_q <= 1'b0;
            if (wd_rst)
                watchdog_reset_flag_q <= 1'b1;
            else if (por_lvl_q
                     || (wr_acc && avs_address_i == OFS_WD_CTRL
                         && !avs_writedata_i[WD_RST_FLAG_POS]))
                watchdog_reset_flag_q <= 1'b0;
            if (por_lvl_q)
                pfail_q <= 1'b1;
            else if (wr_acc && avs_address_i == OFS_STATUS
                     && avs_writedata_i[ST_PFAIL_POS])
                pfail_q <= 1'b0;
            wd_flag_o <= wd_to || (watchdog_timeout_flag_q && !(rst_req
                || (wr_acc && avs_address_i == OFS_WD_CTRL
                    && !avs_writedata_i[WD_TO_FLAG_POS])));
        end
    end

    // counts on peripheral tick in idle
    wdog_timer #(
        .TIMEOUT_TICKS(WD_TIMEOUT_TICKS)
    ) u_wdog (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .tick_i(periph_tick_o),
        .run_i(wd_run_q),
        .clear_i(restart_q || wd_rst),
        .rst_en_i(wd_rst_en_q),
        .timeout_o(wd_to),
        .wd_rst_o(wd_rst)
    );

    // ----------------------------------------
    // avalon slave, one wait state
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wait_q <= 1'b1;
            avs_readdata_o <= '0;
        end
        else
        begin
            wait_q <= !((avs_read_i || avs_write_i) && wait_q);
            if (avs_read_i && wait_q)
            begin
                avs_readdata_o <= '0;
                case (avs_address_i)
                    OFS_PWR_CTRL: avs_readdata_o[IDLE_REQ_POS] <= idle_q;
                    OFS_PWR_MODE:
                        avs_readdata_o[DIV_HI_POS:DIV_LO_POS] <= div_sel_q;
                    OFS_WD_CTRL:
                    begin
                        avs_readdata_o[WD_RESTART_POS] <= restart_q;
                        avs_readdata_o[WD_RST_EN_POS] <= wd_rst_en_q;
                        avs_readdata_o[WD_RST_FLAG_POS] <= watchdog_reset_flag_q;
                        avs_readdata_o[WD_TO_FLAG_POS] <= watchdog_timeout_flag_q;
                        avs_readdata_o[WD_RUN_POS] <= wd_run_q;
                    end
                    OFS_STATUS:
                    begin
                        avs_readdata_o[ST_IDLE_POS] <= idle_q;
                        avs_readdata_o[ST_RST_POS] <= core_rst_o;
                        avs_readdata_o[ST_PFAIL_POS] <= pfail_q;
                    end
                    default: avs_readdata_o <= '0;
                endcase
            end
        end
    end

    assign avs_waitrequest_o = wait_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_idle_write;
        wr_acc && avs_address_i == OFS_PWR_CTRL
        && avs_writedata_i[IDLE_REQ_POS] && !rst_req && !irq_wake_i;
    endsequence

    property p_idle_entry;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_idle_write |=> idle_q && !cpu_clk_en_o;
    endproperty
    a_idle_entry: assert property (p_idle_entry)
        else $error("idle not entered after request");

    property p_idle_pins;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        idle_q |-> strobe_high_o && port_hold_o && !cpu_clk_en_o;
    endproperty
    a_idle_pins: assert property (p_idle_pins)
        else $error("idle outputs wrong");

    property p_wake;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        idle_q && irq_wake_i |=> !idle_q ##1 cpu_clk_en_o || idle_q;
    endproperty
    a_wake: assert property (p_wake)
        else $error("interrupt did not wake");

    property p_rst_idle;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rst_req |=> !idle_q && core_rst_o;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("reset did not end idle");

    property p_mc4;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mc_end && div_sel_q == DIV_4 ##1 (div_sel_q == DIV_4)[*4] |-> mc_end;
    endproperty
    a_mc4: assert property (p_mc4)
        else $error("machine cycle not 4 clocks");

    property p_rsvd;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wr_acc && avs_address_i == OFS_PWR_MODE && !rst_req
        && avs_writedata_i[DIV_HI_POS:DIV_LO_POS] == DIV_RSVD
        |=> $stable(div_sel_q);
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved divide code changed rate");

    property p_idle_tick;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        idle_q ##1 idle_q && periph_tick_o ##1 idle_q[*4] |-> periph_tick_o;
    endproperty
    a_idle_tick: assert property (p_idle_tick)
        else $error("idle peripheral tick not clock/4");

    property p_wd_hold;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wd_rst && st_q == RS_RUN && !por_lvl_q && !pin_det
        |=> core_rst_o[*5];
    endproperty
    a_wd_hold: assert property (p_wd_hold)
        else $error("watchdog reset too short");

    property p_watchdog_reset_flag;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wd_rst |=> watchdog_reset_flag_q;
    endproperty
    a_watchdog_reset_flag: assert property (p_watchdog_reset_flag)
        else $error("watchdog reset flag not set");

    property p_watchdog_timeout_flag;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        wd_to |=> watchdog_timeout_flag_q && wd_flag_o;
    endproperty
    a_watchdog_timeout_flag: assert property (p_watchdog_timeout_flag)
        else $error("timeout flag not set");

    property p_restart;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        restart_q |=> !restart_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart bit did not self-clear");
endmodule

// ===== tb/rst_src_model.sv
`timescale 1ns/1ps
module rst_src_model (
    input wire logic ref_clk_i,
    input wire logic mc_tick_i,
    output logic rst_pin_o
);
    initial rst_pin_o = 1'b0;

    // pin held cycles
    // counted in machine-cycle ends so slow divides still get two samples
    task automatic hold_reset(input int mc);
        rst_pin_o <= 1'b1;
        repeat (mc)
        begin
            @(posedge ref_clk_i);
            while (mc_tick_i !== 1'b1) @(posedge ref_clk_i);
        end
        rst_pin_o <= 1'b0;
    endtask
endmodule

// ===== tb/power_mode_and_reset_control_test.sv
`timescale 1ns/1ps
module power_mode_and_reset_control_test;
    import pmr_pkg::*;
    logic ref_clk_i, resetn_i = 0, avs_read_i = 0, avs_write_i = 0, irq_wake_i = 0;
    logic rst_pin_i, pwr_fail_pin_i = 0, avs_waitrequest_o, cpu_clk_en_o, strobe_high_o;
    logic port_hold_o, core_rst_o, mc_tick_o, fourth_phase_state_o, periph_tick_o, wd_flag_o;
    logic [3:0] avs_address_i = 0, avs_byteenable_i = 4'hf;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o, rd;
    logic [15:0] pc_reset_o;
    logic [7:0] sp_reset_o, port_reset_o;
    int err_count = 0, checks_done = 0, cyc = 0, n, m;

    power_reset_ctrl #(.WD_TIMEOUT_TICKS(8)) uut (.ref_clk_i, .resetn_i, .avs_address_i,
        .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .rst_pin_i, .pwr_fail_pin_i, .irq_wake_i, .cpu_clk_en_o,
        .strobe_high_o, .port_hold_o, .core_rst_o, .pc_reset_o, .sp_reset_o, .port_reset_o,
        .mc_tick_o, .fourth_phase_state_o, .periph_tick_o, .wd_flag_o);
    rst_src_model src (.ref_clk_i, .mc_tick_i(mc_tick_o), .rst_pin_o(rst_pin_i));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // extra edge after release so back-to-back calls never drive twice in one step
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        @(posedge ref_clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic clocks(input int k);
        n = 0;
        m = 0;
        repeat (k)
        begin
            @(posedge ref_clk_i);
            n += (mc_tick_o === 1'b1);
            m += (periph_tick_o === 1'b1);
        end
    endtask

    task automatic wait_rst_low();
        n = 0;
        while (core_rst_o !== 1'b0)
        begin
            @(posedge ref_clk_i);
            n++;
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("pc", pc_reset_o, 16'h0000);
        chk("sp", sp_reset_o, 8'h07);
        chk("port", port_reset_o, 8'hff);
        bus(0, OFS_PWR_MODE, 0);
        chk("div default", rd[7:6], 2'b01);
        bus(0, 4'h2, 0);
        chk("unmapped", rd, 0);
    endtask

    task automatic t_idle();
        bus(1, OFS_PWR_CTRL, 1);
        chk("clk en", cpu_clk_en_o, 0);
        chk("strobe", strobe_high_o, 1);
        chk("port hold", port_hold_o, 1);
        clocks(40);
        chk("idle ticks", m, 10);
        irq_wake_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        irq_wake_i <= 1'b0;
        chk("woken", cpu_clk_en_o, 1);
        bus(0, OFS_PWR_CTRL, 0);
        chk("idle bit", rd[0], 0);
    endtask

    task automatic t_div();
        bus(1, OFS_PWR_MODE, 32'h80);
        clocks(70);
        clocks(128);
        chk("mc 64", n, 2);
        chk("periph 64", m, 2);
        bus(1, OFS_PWR_MODE, 32'h00);
        clocks(128);
        chk("mc rsvd", n, 2);
        bus(1, OFS_PWR_MODE, 32'hc0);
        clocks(1100);
        clocks(1024);
        chk("mc 1024", n, 1);
        bus(1, OFS_PWR_MODE, 32'h40);
        clocks(8);
        clocks(40);
        chk("mc 4", n, 10);
    endtask

    task automatic t_pin();
        bus(1, OFS_PWR_CTRL, 1);
        src.hold_reset(4);
        chk("pin rst", core_rst_o, 1);
        chk("pin wake", cpu_clk_en_o, 1);
        chk("pin strobe", strobe_high_o, 0);
        wait_rst_low();
        chk("rst tail", n <= 16, 1);
        bus(0, OFS_STATUS, 0);
        chk("idle left", rd[0], 0);
        chk("no pf flag", rd[2], 0);
        bus(0, OFS_WD_CTRL, 0);
        chk("no flag", rd[2], 0);
    endtask

    task automatic t_wdog();
        bus(1, OFS_WD_CTRL, 32'h12);
        while (wd_flag_o !== 1'b1) @(posedge ref_clk_i);
        n = 0;
        while (core_rst_o !== 1'b1)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        chk("wd delay", n >= 510 && n <= 516, 1);
        wait_rst_low();
        chk("wd hold", n >= 5 && n <= 9, 1);
        bus(0, OFS_WD_CTRL, 0);
        chk("wd flag", rd[2], 1);
        chk("wd run", rd[4], 1);
        repeat (12)
        begin
            // restart inside timeout
            // reset flag written as one so it survives for the power-fail case
            bus(1, OFS_WD_CTRL, 32'h17);
            repeat (12) @(posedge ref_clk_i);
            chk("restarted", wd_flag_o, 0);
        end
        bus(0, OFS_WD_CTRL, 0);
        chk("restart self clear", rd[0], 0);
        bus(1, OFS_PWR_CTRL, 1);
        bus(1, OFS_WD_CTRL, 32'h15);
        while (wd_flag_o !== 1'b1) @(posedge ref_clk_i);
        chk("wd in idle", cpu_clk_en_o, 0);
        n = 0;
        repeat (600)
        begin
            @(posedge ref_clk_i);
            n += (core_rst_o !== 1'b0);
        end
        chk("no wd rst", n, 0);
        bus(1, OFS_WD_CTRL, 32'h14);
    endtask

    task automatic t_pfail();
        pwr_fail_pin_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        chk("pf rst", core_rst_o, 1);
        pwr_fail_pin_i <= 1'b0;
        wait_rst_low();
        chk("pf wake", port_hold_o, 0);
        bus(0, OFS_WD_CTRL, 0);
        chk("pf wd off", rd[4], 0);
        chk("pf watchdog_reset_flag", rd[2], 0);
        bus(0, OFS_STATUS, 0);
        chk("pf flag", rd[2], 1);
        bus(1, OFS_STATUS, 32'h4);
        bus(0, OFS_STATUS, 0);
        chk("pf clr", rd[2], 0);
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        wait_rst_low();
        t_reset();
        t_idle();
        t_div();
        t_pin();
        t_wdog();
        t_pfail();
        report_and_stop();
    end
endmodule
